// >>> rpcg_pkg.sv
package rpcg_pkg;

  // ----------------------------------------------------------------
  // Bus layout
  // ----------------------------------------------------------------
  localparam int          RPCG_DATA_W         = 32;
  localparam int          RPCG_NUM_PERIPH     = 13;
  localparam logic [31:0] RPCG_BASE_ADDR      = 32'h400F_E000;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [31:0] RPCG_OFS_RUN_GATE   = 32'h0000_0104;
  localparam logic [31:0] RPCG_OFS_SLEEP_GATE = 32'h0000_0114;
  localparam logic [31:0] RPCG_OFS_DEEP_GATE  = 32'h0000_0124;
  localparam logic [31:0] RPCG_OFS_RUN_CFG    = 32'h0000_0200;
  localparam logic [31:0] RPCG_OFS_IRQ_STAT   = 32'h0000_0210;
  localparam logic [31:0] RPCG_OFS_IRQ_MASK   = 32'h0000_0214;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RPCG_RST_GATE       = 32'h0000_0000;
  localparam logic [31:0] RPCG_RST_CFG        = 32'h0000_0000;
  localparam logic [12:0] RPCG_RST_VEC        = 13'h0000;

  // ----------------------------------------------------------------
  // Gate field positions
  // ----------------------------------------------------------------
  localparam int RPCG_POS_ASYNC_PORT_A  = 0;
  localparam int RPCG_POS_ASYNC_PORT_B  = 1;
  localparam int RPCG_POS_ASYNC_PORT_C  = 2;
  localparam int RPCG_POS_SYNC_SERIAL_A = 4;
  localparam int RPCG_POS_SYNC_SERIAL_B = 5;
  localparam int RPCG_POS_TWO_WIRE_A    = 12;
  localparam int RPCG_POS_TWO_WIRE_B    = 14;
  localparam int RPCG_POS_GP_COUNTER_A  = 16;
  localparam int RPCG_POS_GP_COUNTER_B  = 17;
  localparam int RPCG_POS_GP_COUNTER_C  = 18;
  localparam int RPCG_POS_GP_COUNTER_D  = 19;
  localparam int RPCG_POS_COMPARATOR_A  = 24;
  localparam int RPCG_POS_COMPARATOR_B  = 25;
  localparam int RPCG_POS_AUTO_GATING   = 0;

  // Peripheral index to register bit position
  localparam int RPCG_GATE_POS [RPCG_NUM_PERIPH] = '{
    RPCG_POS_ASYNC_PORT_A, RPCG_POS_ASYNC_PORT_B, RPCG_POS_ASYNC_PORT_C,
    RPCG_POS_SYNC_SERIAL_A, RPCG_POS_SYNC_SERIAL_B,
    RPCG_POS_TWO_WIRE_A, RPCG_POS_TWO_WIRE_B,
    RPCG_POS_GP_COUNTER_A, RPCG_POS_GP_COUNTER_B, RPCG_POS_GP_COUNTER_C, RPCG_POS_GP_COUNTER_D,
    RPCG_POS_COMPARATOR_A, RPCG_POS_COMPARATOR_B
  };

  // Writable bits of each gate register and of the run config register
  localparam logic [31:0] RPCG_GATE_WMASK     = 32'h030F_5037;
  localparam logic [31:0] RPCG_CFG_WMASK      = 32'h0000_0001;

endpackage

// >>> rpcg_run_gate.sv
`timescale 1ns/10ps
// Operation
// - Each writable gate bit drives one peripheral clock enable, set meaning clocked and clear meaning unclocked.
// - An access to a peripheral whose gate is clear gets a bus fault instead of a normal access.
// - After reset the run gate register holds zero so every peripheral starts unclocked.
// - The run gate register steers the enables while the system is in normal run mode.
// - The sleep and deep-sleep gate registers act only while the automatic gating bit is set.
// - Bit 25 gates comparator B and bit 24 comparator A, both read/write.
// - Bits 19 to 16 gate general-purpose counters D, C, B and A, each read/write.
// - Bit 14 gates two-wire module B and bit 12 two-wire module A.
// - Bit 5 gates synchronous serial module B and bit 4 module A.
// - Bits 2, 1 and 0 gate asynchronous ports C, B and A.
// - The run gate register is decoded at offset 0x104 from the control base address.
module rpcg_run_gate
  import rpcg_pkg::*;
#(
  parameter int          NUM_PERIPH = RPCG_NUM_PERIPH,
  parameter logic [31:0] BASE_ADDR  = RPCG_BASE_ADDR
)
(
  input  wire logic                  CLK_SYS,
  input  wire logic                  RST,
  input  wire logic                  WB_CYC_I,
  input  wire logic                  WB_STB_I,
  input  wire logic                  WB_WE_I,
  input  wire logic [31:0]           WB_ADR_I,
  input  wire logic [3:0]            WB_SEL_I,
  input  wire logic [31:0]           WB_DAT_I,
  output logic      [31:0]           WB_DAT_O,
  output logic                       WB_ACK_O,
  output logic                       WB_ERR_O,
  input  wire logic                  SYS_SLEEP,
  input  wire logic                  SYS_DEEPSLEEP,
  input  wire logic [NUM_PERIPH-1:0] PERIPH_REQ,
  output logic      [NUM_PERIPH-1:0] PERIPH_FAULT,
  output logic      [NUM_PERIPH-1:0] PERIPH_CLK_EN,
  output logic                       IRQ
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0]           run_gate_reg;
  logic [31:0]           run_gate_next;
  logic [31:0]           sleep_gate_reg;
  logic [31:0]           sleep_gate_next;
  logic [31:0]           deep_gate_reg;
  logic [31:0]           deep_gate_next;
  logic [31:0]           run_cfg_reg;
  logic [31:0]           run_cfg_next;
  logic [NUM_PERIPH-1:0] irq_stat_reg;
  logic [NUM_PERIPH-1:0] irq_stat_next;
  logic [NUM_PERIPH-1:0] irq_mask_reg;
  logic [NUM_PERIPH-1:0] irq_mask_next;
  logic [NUM_PERIPH-1:0] clk_en_reg;
  logic [NUM_PERIPH-1:0] clk_en_next;
  logic [31:0]           dat_reg;
  logic [31:0]           dat_next;
  logic                  ack_reg;
  logic                  ack_next;
  logic                  err_reg;
  logic                  err_next;

  logic [NUM_PERIPH-1:0] run_vec;
  logic [NUM_PERIPH-1:0] sleep_vec;
  logic [NUM_PERIPH-1:0] deep_vec;
  logic [NUM_PERIPH-1:0] fault_evt;
  logic [31:0]           byte_mask;
  logic [31:0]           offset;
  logic                  req_new;
  logic                  auto_gating_select;

  // ----------------------------------------------------------------
  // Gate bit to peripheral mapping
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_PERIPH; i++)
  begin : g_map
    assign run_vec[i]   = run_gate_reg[RPCG_GATE_POS[i]];
    assign sleep_vec[i] = sleep_gate_reg[RPCG_GATE_POS[i]];
    assign deep_vec[i]  = deep_gate_reg[RPCG_GATE_POS[i]];
  end

  assign auto_gating_select = run_cfg_reg[RPCG_POS_AUTO_GATING];
  assign offset             = WB_ADR_I - BASE_ADDR;
  assign req_new            = WB_CYC_I & WB_STB_I & ~ack_reg & ~err_reg;
  assign byte_mask          = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

  // Fault is combinational so the peripheral bus can answer in the same cycle
  assign fault_evt    = PERIPH_REQ & ~clk_en_reg;
  assign PERIPH_FAULT = fault_evt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    run_gate_next   = run_gate_reg;
    sleep_gate_next = sleep_gate_reg;
    deep_gate_next  = deep_gate_reg;
    run_cfg_next    = run_cfg_reg;
    irq_mask_next   = irq_mask_reg;
    irq_stat_next   = irq_stat_reg;
    dat_next        = dat_reg;
    ack_next        = 1'b0;
    err_next        = 1'b0;
    if (req_new)
    begin
      ack_next = 1'b1;
      dat_next = 32'h0000_0000;
      case (offset)
        RPCG_OFS_RUN_GATE:
        begin
          dat_next = run_gate_reg;
          if (WB_WE_I)
          begin
            // Reserved positions are never stored, so they read back as zero
            run_gate_next = (run_gate_reg & ~(byte_mask & RPCG_GATE_WMASK))
                          | (WB_DAT_I & byte_mask & RPCG_GATE_WMASK);
          end
        end
        RPCG_OFS_SLEEP_GATE:
        begin
          dat_next = sleep_gate_reg;
          if (WB_WE_I)
          begin
            sleep_gate_next = (sleep_gate_reg & ~(byte_mask & RPCG_GATE_WMASK))
                            | (WB_DAT_I & byte_mask & RPCG_GATE_WMASK);
          end
        end
        RPCG_OFS_DEEP_GATE:
        begin
          dat_next = deep_gate_reg;
          if (WB_WE_I)
          begin
            deep_gate_next = (deep_gate_reg & ~(byte_mask & RPCG_GATE_WMASK))
                           | (WB_DAT_I & byte_mask & RPCG_GATE_WMASK);
          end
        end
        RPCG_OFS_RUN_CFG:
        begin
          dat_next = run_cfg_reg;
          if (WB_WE_I)
          begin
            run_cfg_next = (run_cfg_reg & ~(byte_mask & RPCG_CFG_WMASK))
                         | (WB_DAT_I & byte_mask & RPCG_CFG_WMASK);
          end
        end
        RPCG_OFS_IRQ_STAT:
        begin
          dat_next[NUM_PERIPH-1:0] = irq_stat_reg;
          if (WB_WE_I)
          begin
            irq_stat_next = irq_stat_reg & ~(WB_DAT_I[NUM_PERIPH-1:0] & byte_mask[NUM_PERIPH-1:0]);
          end
        end
        RPCG_OFS_IRQ_MASK:
        begin
          dat_next[NUM_PERIPH-1:0] = irq_mask_reg;
          if (WB_WE_I)
          begin
            irq_mask_next = (irq_mask_reg & ~byte_mask[NUM_PERIPH-1:0])
                          | (WB_DAT_I[NUM_PERIPH-1:0] & byte_mask[NUM_PERIPH-1:0]);
          end
        end
        default:
        begin
          ack_next = 1'b0;
          err_next = 1'b1;
        end
      endcase
    end
    // A fault in the cycle of a clear still leaves its flag set
    irq_stat_next = irq_stat_next | fault_evt;
  end

  // Enable select; registered so each enable changes only on a clock edge and the
  // peripheral's latch-based gate cell sees a clean level
  always_comb
  begin
    clk_en_next = run_vec;
    if (auto_gating_select && SYS_DEEPSLEEP)
    begin
      clk_en_next = deep_vec;
    end
    else if (auto_gating_select && SYS_SLEEP)
    begin
      clk_en_next = sleep_vec;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      run_gate_reg   <= RPCG_RST_GATE;
      sleep_gate_reg <= RPCG_RST_GATE;
      deep_gate_reg  <= RPCG_RST_GATE;
      run_cfg_reg    <= RPCG_RST_CFG;
      irq_stat_reg   <= RPCG_RST_VEC;
      irq_mask_reg   <= RPCG_RST_VEC;
      clk_en_reg     <= RPCG_RST_VEC;
      dat_reg        <= RPCG_RST_GATE;
      ack_reg        <= 1'b0;
      err_reg        <= 1'b0;
    end
    else
    begin
      run_gate_reg   <= run_gate_next;
      sleep_gate_reg <= sleep_gate_next;
      deep_gate_reg  <= deep_gate_next;
      run_cfg_reg    <= run_cfg_next;
      irq_stat_reg   <= irq_stat_next;
      irq_mask_reg   <= irq_mask_next;
      clk_en_reg     <= clk_en_next;
      dat_reg        <= dat_next;
      ack_reg        <= ack_next;
      err_reg        <= err_next;
    end
  end

  assign WB_DAT_O      = dat_reg;
  assign WB_ACK_O      = ack_reg;
  assign WB_ERR_O      = err_reg;
  assign PERIPH_CLK_EN = clk_en_reg;
  assign IRQ           = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence s_run_write;
    req_new && WB_WE_I && (offset == RPCG_OFS_RUN_GATE) && (WB_SEL_I == 4'hF);
  endsequence

  sequence s_run_mode;
    !SYS_SLEEP && !SYS_DEEPSLEEP;
  endsequence

  // Uses the live reset level so the very first edge never sees an unknown history
  property p_reset_zero;
    RST |=> (run_gate_reg == RPCG_RST_GATE) && (PERIPH_CLK_EN == RPCG_RST_VEC);
  endproperty
  a_reset_zero: assert property (disable iff (1'b0) p_reset_zero) else $error("gate not zero after reset");

  property p_write_run;
    s_run_write |=> (run_gate_reg == ($past(WB_DAT_I) & RPCG_GATE_WMASK)) && WB_ACK_O;
  endproperty
  a_write_run: assert property (p_write_run) else $error("run gate write lost");

  property p_reserved_zero;
    (run_gate_reg & ~RPCG_GATE_WMASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit stored");

  property p_fault;
    PERIPH_FAULT == (PERIPH_REQ & ~PERIPH_CLK_EN);
  endproperty
  a_fault: assert property (p_fault) else $error("fault does not follow gate");

  property p_fault_sticky;
    (|PERIPH_FAULT) |=> ((irq_stat_reg & $past(PERIPH_FAULT)) == $past(PERIPH_FAULT));
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault flag not set");

  property p_run_mode;
    s_run_mode |=> (PERIPH_CLK_EN == $past(run_vec));
  endproperty
  a_run_mode: assert property (p_run_mode) else $error("run enables wrong");

  property p_no_auto;
    !auto_gating_select |=> (PERIPH_CLK_EN == $past(run_vec));
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("sleep gating without auto bit");

  property p_sleep_sel;
    auto_gating_select && SYS_SLEEP && !SYS_DEEPSLEEP |=> (PERIPH_CLK_EN == $past(sleep_vec));
  endproperty
  a_sleep_sel: assert property (p_sleep_sel) else $error("sleep enables wrong");

  property p_comparator;
    s_run_mode |=> (PERIPH_CLK_EN[12:11] == $past(run_gate_reg[25:24]));
  endproperty
  a_comparator: assert property (p_comparator) else $error("comparator gate wrong");

  property p_counter;
    s_run_mode |=> (PERIPH_CLK_EN[10:7] == $past(run_gate_reg[19:16]));
  endproperty
  a_counter: assert property (p_counter) else $error("counter gate wrong");

  property p_serial;
    s_run_mode |=> (PERIPH_CLK_EN[6:5] == {$past(run_gate_reg[14]), $past(run_gate_reg[12])})
                && (PERIPH_CLK_EN[4:3] == $past(run_gate_reg[5:4]))
                && (PERIPH_CLK_EN[2:0] == $past(run_gate_reg[2:0]));
  endproperty
  a_serial: assert property (p_serial) else $error("serial gate wrong");

  property p_ack_pulse;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

endmodule

// >>> rpcg_dummy_unused.sv
`timescale 1ns/10ps

// >>> rpcg_run_gate_tb.sv
`timescale 1ns/10ps
module rpcg_run_gate_tb
  import rpcg_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic        clk_sys  = 1'b0;
  logic        rst      = 1'b1;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic [31:0] adr      = 32'h0000_0000;
  logic [3:0]  sel      = 4'h0;
  logic [31:0] wdat     = 32'h0000_0000;
  logic        sleep    = 1'b0;
  logic        deep     = 1'b0;
  logic [12:0] req      = 13'h0000;
  logic [31:0] rdat;
  logic        ack;
  logic        err;
  logic        irq;
  logic [12:0] fault;
  logic [12:0] en;
  logic [33:0] exp_q [$];
  logic [33:0] e_head;
  logic [31:0] shadow;
  logic [31:0] d;
  logic [3:0]  s;
  int          i;
  int          n_errors  = 0;
  int          tests_run = 0;
  int          seed      = 32'h9A92;

  rpcg_run_gate dut (
    .CLK_SYS(clk_sys), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .WB_ERR_O(err),
    .SYS_SLEEP(sleep), .SYS_DEEPSLEEP(deep), .PERIPH_REQ(req), .PERIPH_FAULT(fault),
    .PERIPH_CLK_EN(en), .IRQ(irq)
  );

  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check_bus(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t bus got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_pin(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t pin got %h exp %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Wishbone master; the note goes in before the request rises
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [31:0] ofs, d, input logic [3:0] s, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= RPCG_BASE_ADDR + ofs;
    wdat <= d;
    sel  <= s;
    // Wait until ack or err is seen; the watchdog ends a wait that never completes
    do
    begin
      @(posedge clk_sys);
    end
    while (ack !== 1'b1 && err !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [31:0] ofs, d, input logic [3:0] s = 4'hF);
    wb(1'b1, ofs, d, s, {2'b00, 32'h0000_0000});
  endtask

  task automatic rd(input logic [31:0] ofs, exp);
    wb(1'b0, ofs, 32'h0000_0000, 4'hF, {2'b01, exp});
  endtask

  task automatic bad(input logic [31:0] ofs, input logic w);
    wb(w, ofs, 32'hFFFF_FFFF, 4'hF, {2'b10, 32'h0000_0000});
  endtask

  // Enables select one cycle late, so two edges always suffice
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  function automatic logic [12:0] to_en(input logic [31:0] r);
    logic [12:0] v;
    for (int k = 0; k < RPCG_NUM_PERIPH; k++)
      v[k] = r[RPCG_GATE_POS[k]];
    return v;
  endfunction

  // Pre-edge values are seen here, so no race with the registered outputs
  always @(posedge clk_sys)
  begin
    if (ack === 1'b1 || err === 1'b1)
    begin
      e_head = (exp_q.size() > 0) ? exp_q.pop_front() : {2'b11, 32'hDEAD_BEEF};
      check_bus({err, e_head[32] ? rdat : 32'h0000_0000}, {e_head[33], e_head[31:0]});
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check_pin({19'h0, en}, 32'h0000_0000);
    rd(RPCG_OFS_RUN_GATE, RPCG_RST_GATE);
    for (i = 0; i < RPCG_NUM_PERIPH; i++)
    begin
      wr(RPCG_OFS_RUN_GATE, 32'h0000_0001 << RPCG_GATE_POS[i]);
      rd(RPCG_OFS_RUN_GATE, 32'h0000_0001 << RPCG_GATE_POS[i]);
      settle();
      check_pin({19'h0, en}, {19'h0, 13'h0001 << i});
    end
    wr(RPCG_OFS_RUN_GATE, 32'hFFFF_FFFF);
    rd(RPCG_OFS_RUN_GATE, RPCG_GATE_WMASK);
    shadow = RPCG_GATE_WMASK;
    for (i = 0; i < 8; i++)
    begin
      d = $random(seed);
      s = $random(seed);
      wr(RPCG_OFS_RUN_GATE, d, s);
      for (int b = 0; b < 4; b++)
        if (s[b])
          shadow[8*b +: 8] = d[8*b +: 8];
      shadow = shadow & RPCG_GATE_WMASK;
      rd(RPCG_OFS_RUN_GATE, shadow);
      settle();
      check_pin({19'h0, en}, {19'h0, to_en(shadow)});
    end
    // Read-modify-write: flip one gate, write back everything else as read
    shadow = shadow ^ 32'h0000_0010;
    wr(RPCG_OFS_RUN_GATE, shadow);
    bad(32'h0000_0108, 1'b1);
    bad(32'h0000_0100, 1'b0);
    bad(32'h0001_0104, 1'b1);
    rd(RPCG_OFS_RUN_GATE, shadow);
    // Faults raise status; bit 12 is masked off on purpose
    wr(RPCG_OFS_RUN_GATE, 32'h0000_0001);
    wr(RPCG_OFS_IRQ_MASK, 32'h0000_0FFF);
    @(posedge clk_sys);
    req <= 13'h1001;
    @(negedge clk_sys);
    check_pin({19'h0, fault}, 32'h0000_1000);
    @(posedge clk_sys);
    req <= 13'h0000;
    settle();
    check_pin({31'h0, irq}, 32'h0000_0000);
    rd(RPCG_OFS_IRQ_STAT, 32'h0000_1000);
    @(posedge clk_sys);
    req <= 13'h0004;
    @(posedge clk_sys);
    req <= 13'h0000;
    settle();
    check_pin({31'h0, irq}, 32'h0000_0001);
    wr(RPCG_OFS_IRQ_STAT, 32'h0000_1FFF);
    rd(RPCG_OFS_IRQ_STAT, 32'h0000_0000);
    settle();
    check_pin({31'h0, irq}, 32'h0000_0000);
    // Low-power gates stay inert until automatic gating is selected
    wr(RPCG_OFS_SLEEP_GATE, 32'h0000_0030);
    wr(RPCG_OFS_DEEP_GATE, 32'h0300_0000);
    @(posedge clk_sys);
    sleep <= 1'b1;
    settle();
    check_pin({19'h0, en}, 32'h0000_0001);
    wr(RPCG_OFS_RUN_CFG, 32'h0000_0001);
    settle();
    check_pin({19'h0, en}, 32'h0000_0018);
    @(posedge clk_sys);
    deep <= 1'b1;
    settle();
    check_pin({19'h0, en}, 32'h0000_1800);
    @(posedge clk_sys);
    sleep <= 1'b0;
    deep  <= 1'b0;
    settle();
    check_pin({19'h0, en}, 32'h0000_0001);
    wr(RPCG_OFS_RUN_GATE, 32'hFFFF_FFFF);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    settle();
    check_pin({19'h0, en}, 32'h0000_0000);
    rd(RPCG_OFS_RUN_GATE, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
